// ---- hw/sia_agent.sv ----
/*
  Serial interrupt slave agent with PCI clock-run restart. Watches the
  parallel interrupts and a DMA request, restarts a stopped PCI clock over
  the open-drain clock-run pin, and reports interrupt levels in data frames
  on the shared open-drain serial interrupt line.
  Assumes: clk is much faster than the PCI clock; the PCI clock, bus reset
  and both open-drain lines arrive from pins; interrupt inputs, the DMA
  request and the mode write come from logic on clk.
*/
// What this block does
// - Enable bit low disables serial reporting and clock-run; high enables both.
// - Serial interrupt enable bit resets to one.
// - Clock-run high means clock stopped; low means clock running.
// - Interrupt change or DMA request while clock-run high: drive clock-run low.
// - Hold clock-run low for two PCI clock rises, then release the driver.
// - Never drive clock-run while the clock generator already holds it low.
// - Never assert clock-run while serial reporting is disabled.
// - Assert clock-run only after two consecutive clocks seen deasserted.
// - Triggers: either edge of any routed interrupt, or DMA request assertion.
// - Change detection runs off the system clock, in both modes.
// - Keep reasserting clock-run until the change is delivered in a cycle.
// - Idle clocks may follow a stop; next start may follow at once.
// - Quiet mode: device starts with one low clock, then tri-states.
// - No start while the line is active between start and stop.
// - Quiet mode: any transition starts a frame unless deliverable now.
// - Continuous mode: only the host starts frames; device stays passive.
// - Mode changes only in stop frames; reset gives continuous mode.
// - Measure every stop pulse width to pick the next mode.
// - Data frame: sample low if interrupt low, recovery high, turn-around off.
// - Frame N sample is 3N-1 clocks after start rise; frame 1 unused.
// - New start no earlier than second clock after stop pulse rise.
// - During bus reset tri-state the line and return to continuous mode.
`timescale 1ns/1ps

module sia_agent (
  // System clock and reset
  input wire logic clk,
  input wire logic resetn,
  // PCI clock and bus reset pins
  input wire logic pci_clk,
  input wire logic bus_reset_n,
  // Serial interrupt line, open drain
  input wire logic serial_interrupt_in,
  output logic serial_interrupt_out,
  output logic serial_interrupt_oe,
  // Clock-run line, open drain, active low
  input wire logic clkrun_n_in,
  output logic clkrun_n_out,
  output logic clkrun_n_oe,
  // Internal interrupt and DMA requests
  input wire logic [sia_pkg::IRQ_WIDTH-1:0] irq_data,
  input wire logic system_mgmt_interrupt_n,
  input wire logic smi_on_frame3,
  input wire logic dma_req,
  // Device mode register, enable bit write
  input wire logic mode_write,
  input wire logic mode_write_value,
  // Status
  output logic serial_irq_enable,
  output logic quiet_mode,
  output logic change_pending
);

  logic rst_meta;
  logic rst_n;
  logic [sia_pkg::SYNC_WIDTH-1:0] sync_meta;
  logic [sia_pkg::SYNC_WIDTH-1:0] sync_pin;
  logic pci_prev;
  logic pci_rise;
  logic bus_rst;
  logic line;
  logic crun_high;
  logic [sia_pkg::LAST_FRAME:sia_pkg::FIRST_FRAME] frame_val;
  logic [sia_pkg::LAST_FRAME:sia_pkg::FIRST_FRAME] frame_prev;
  logic change;
  logic dma_prev;
  logic dma_rise;
  logic dma_pending;
  logic captured;
  logic start_rise;
  logic cycle_done;
  logic [1:0] crun_high_cnt;
  logic [1:0] hold_cnt;
  sia_pkg::sia_crun_state_type crun_state;
  logic crun_request;
  sia_pkg::sia_ser_state_type ser_state;
  sia_pkg::sia_mode_type mode;
  logic [1:0] phase;
  logic [4:0] frame;
  logic [1:0] next_phase;
  logic [4:0] next_frame;
  logic [1:0] low_run;
  logic [1:0] gap_cnt;
  logic drove_low;
  logic may_start;
  logic next_val;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Two-stage synchronisers for all pin inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta <= sia_pkg::SYNC_RESET;
      sync_pin <= sia_pkg::SYNC_RESET;
    end else begin
      sync_meta <= {clkrun_n_in, serial_interrupt_in, bus_reset_n, pci_clk};
      sync_pin <= sync_meta;
    end
  end

  assign bus_rst = !sync_pin[sia_pkg::SYNC_BUS_RST];
  assign line = sync_pin[sia_pkg::SYNC_SERIAL];
  assign crun_high = sync_pin[sia_pkg::SYNC_CLKRUN];

  // PCI clock rising edge finder, reset to the synchroniser level so no false rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pci_prev <= sia_pkg::SYNC_RESET[sia_pkg::SYNC_PCI_CLK];
    end else begin
      pci_prev <= sync_pin[sia_pkg::SYNC_PCI_CLK];
    end
  end

  assign pci_rise = sync_pin[sia_pkg::SYNC_PCI_CLK] && !pci_prev;

  // Enable bit of the device mode register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_irq_enable <= sia_pkg::ENABLE_RESET;
    end else if (mode_write) begin
      serial_irq_enable <= mode_write_value;
    end
  end

  // Value carried by each data frame
  genvar f;
  generate
    for (f = sia_pkg::FIRST_FRAME; f <= sia_pkg::LAST_FRAME; f++) begin : g_frame
      if (f == sia_pkg::FIRST_FRAME) begin : g_unused
        assign frame_val[f] = 1'b1;
      end else if (f == sia_pkg::SMI_FRAME) begin : g_smi
        // Frame three: interrupt two or management interrupt
        assign frame_val[f] = smi_on_frame3 ? system_mgmt_interrupt_n : irq_data[f-1];
      end else begin : g_irq
        assign frame_val[f] = irq_data[f-1];
      end
    end
  endgenerate

  // Edge history of routed interrupts and the DMA request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_prev <= '1;
      dma_prev <= 1'b0;
    end else begin
      frame_prev <= frame_val;
      dma_prev <= dma_req;
    end
  end

  // Sampled on the fast clock, independent of PCI clock and mode
  assign change = |(frame_val ^ frame_prev);
  assign dma_rise = dma_req && !dma_prev;

  // Pending change, cleared by a completed cycle that carried it or by bus reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      change_pending <= 1'b0;
      captured <= 1'b0;
    end else if (bus_rst) begin
      change_pending <= 1'b0;
      captured <= 1'b0;
    end else begin
      // Change stays pending until delivered; new change wins
      change_pending <= change || (change_pending && !(cycle_done && captured));
      if (change) begin
        captured <= 1'b0;
      end else if (start_rise) begin
        captured <= change_pending;
      end else if (cycle_done) begin
        captured <= 1'b0;
      end
    end
  end

  // Clocks seen with clock-run deasserted, held while the clock stands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crun_high_cnt <= 2'h0;
    end else if (pci_rise) begin
      if (!crun_high) begin
        crun_high_cnt <= 2'h0;
      end else if (crun_high_cnt != sia_pkg::CLKRUN_IDLE_CLOCKS) begin
        crun_high_cnt <= crun_high_cnt + 2'h1;
      end
    end
  end

  // Restart request while the clock is stopped
  // Not while the generator holds the line low
  assign crun_request = serial_irq_enable && (change_pending || dma_pending)
                        && crun_high && !bus_rst
                        && (crun_high_cnt == sia_pkg::CLKRUN_IDLE_CLOCKS);

  // Clock-run driver
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crun_state <= sia_pkg::crun_idle;
      hold_cnt <= 2'h0;
    end else begin
      case (crun_state)
        sia_pkg::crun_idle: begin
          hold_cnt <= 2'h0;
          // Reassert whenever the clock stops again
          if (crun_request) begin
            crun_state <= sia_pkg::crun_drive;
          end
        end
        sia_pkg::crun_drive: begin
          if (!serial_irq_enable || bus_rst) begin
            crun_state <= sia_pkg::crun_idle;
          end else if (pci_rise) begin
            // Release after the second rising edge
            if (hold_cnt + 2'h1 == sia_pkg::CLKRUN_HOLD_EDGES) begin
              crun_state <= sia_pkg::crun_idle;
            end
            hold_cnt <= hold_cnt + 2'h1;
          end
        end
        default: begin
          crun_state <= sia_pkg::crun_idle;
        end
      endcase
    end
  end

  // DMA assertion is served once the clock has been restarted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_pending <= 1'b0;
    end else if (dma_rise) begin
      dma_pending <= 1'b1;
    end else if (bus_rst || !serial_irq_enable) begin
      dma_pending <= 1'b0;
    end else if (crun_state == sia_pkg::crun_drive && pci_rise
                 && hold_cnt + 2'h1 == sia_pkg::CLKRUN_HOLD_EDGES) begin
      dma_pending <= 1'b0;
    end
  end

  // Clock-run pin: only ever pulls low
  assign clkrun_n_out = 1'b0;
  assign clkrun_n_oe = (crun_state == sia_pkg::crun_drive);

  // Frame phase stepping, the sample clock falls on phase two
  always_comb begin
    next_phase = (phase == sia_pkg::PHASE_SAMPLE) ? sia_pkg::PHASE_RECOVERY : phase + 2'h1;
    next_frame = frame;
    if (phase == sia_pkg::PHASE_TURN && frame != 5'h1F) begin
      next_frame = frame + 5'h01;
    end
    next_val = 1'b1;
    if (next_frame >= sia_pkg::FIRST_FRAME && next_frame <= sia_pkg::LAST_FRAME) begin
      next_val = frame_val[next_frame];
    end
  end

  // Quiet mode start for a pending change
  // Not before the second clock after the stop rise
  assign may_start = (ser_state == sia_pkg::ser_idle) && (mode == sia_pkg::mode_quiet)
                     && serial_irq_enable && change_pending && line
                     && (gap_cnt == sia_pkg::START_GAP);

  // Line cycle tracker
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_state <= sia_pkg::ser_idle;
      phase <= sia_pkg::PHASE_TURN;
      frame <= 5'h00;
      low_run <= 2'h0;
      gap_cnt <= 2'h0;
    end else if (bus_rst) begin
      ser_state <= sia_pkg::ser_idle;
      phase <= sia_pkg::PHASE_TURN;
      frame <= 5'h00;
      low_run <= 2'h0;
      gap_cnt <= 2'h0;
    end else if (pci_rise) begin
      case (ser_state)
        sia_pkg::ser_idle: begin
          if (gap_cnt != sia_pkg::START_GAP) begin
            gap_cnt <= gap_cnt + 2'h1;
          end
          // Start pulse from any agent, ours included
          if (!line) begin
            ser_state <= sia_pkg::ser_start;
          end
        end
        sia_pkg::ser_start: begin
          // Frame counting begins at the start pulse rise
          if (line) begin
            ser_state <= sia_pkg::ser_frames;
            phase <= sia_pkg::PHASE_TURN;
            frame <= 5'h00;
            low_run <= 2'h0;
          end
        end
        sia_pkg::ser_frames: begin
          phase <= next_phase;
          frame <= next_frame;
          // Measure each low run; single clocks are data
          if (!line) begin
            if (low_run != sia_pkg::STOP_CONT_LEN) begin
              low_run <= low_run + 2'h1;
            end
          end else begin
            low_run <= 2'h0;
            if (low_run >= sia_pkg::STOP_QUIET_LEN) begin
              // Idle after the stop, count toward next start
              ser_state <= sia_pkg::ser_idle;
              gap_cnt <= 2'h1;
            end
          end
        end
        default: begin
          ser_state <= sia_pkg::ser_idle;
        end
      endcase
    end
  end

  assign start_rise = pci_rise && (ser_state == sia_pkg::ser_start) && line && !bus_rst;
  assign cycle_done = pci_rise && (ser_state == sia_pkg::ser_frames) && line
                      && (low_run >= sia_pkg::STOP_QUIET_LEN) && !bus_rst;

  // Mode latched at the end of each stop pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= sia_pkg::mode_continuous;
    end else if (bus_rst) begin
      // Bus reset returns to continuous mode
      mode <= sia_pkg::mode_continuous;
    end else if (cycle_done) begin
      // Two clocks quiet, three or more continuous
      mode <= (low_run == sia_pkg::STOP_QUIET_LEN) ? sia_pkg::mode_quiet
                                                   : sia_pkg::mode_continuous;
    end
  end

  assign quiet_mode = (mode == sia_pkg::mode_quiet);

  // Serial line driver
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_interrupt_out <= 1'b1;
      serial_interrupt_oe <= 1'b0;
      drove_low <= 1'b0;
    end else if (bus_rst || !serial_irq_enable) begin
      serial_interrupt_out <= 1'b1;
      serial_interrupt_oe <= 1'b0;
      drove_low <= 1'b0;
    end else if (pci_rise) begin
      serial_interrupt_out <= 1'b1;
      serial_interrupt_oe <= 1'b0;
      if (may_start) begin
        // One low clock, then released without driving high
        serial_interrupt_out <= 1'b0;
        serial_interrupt_oe <= 1'b1;
      end else if (ser_state == sia_pkg::ser_frames) begin
        // Sample low, recovery high, turn-around released
        if (next_phase == sia_pkg::PHASE_SAMPLE) begin
          drove_low <= !next_val;
          if (!next_val) begin
            serial_interrupt_out <= 1'b0;
            serial_interrupt_oe <= 1'b1;
          end
        end else if (next_phase == sia_pkg::PHASE_RECOVERY) begin
          serial_interrupt_oe <= drove_low;
          drove_low <= 1'b0;
        end else begin
          drove_low <= 1'b0;
        end
      end else begin
        drove_low <= 1'b0;
      end
    end
  end

endmodule : sia_agent

// ---- hw/sia_pkg.sv ----
/*
  Constants, state and mode types for the serial interrupt agent with
  clock-restart support. Assumes a single system clock that samples the
  PCI clock pin and finds its edges.
*/
package sia_pkg;

  // Parallel interrupt vector carried in data frames
  localparam int unsigned IRQ_WIDTH = 16;
  localparam logic [4:0] FIRST_FRAME = 5'h01;
  localparam logic [4:0] LAST_FRAME = 5'h10;
  localparam logic [4:0] SMI_FRAME = 5'h03;

  // Data frame phases, three clocks per frame
  localparam logic [1:0] PHASE_RECOVERY = 2'h0;
  localparam logic [1:0] PHASE_TURN = 2'h1;
  localparam logic [1:0] PHASE_SAMPLE = 2'h2;

  // Stop pulse widths, in PCI clocks
  localparam logic [1:0] STOP_QUIET_LEN = 2'h2;
  localparam logic [1:0] STOP_CONT_LEN = 2'h3;

  // Clocks after the stop pulse rising edge before a new start
  localparam logic [1:0] START_GAP = 2'h2;

  // Clock-run handshake counts, in PCI clocks
  localparam logic [1:0] CLKRUN_HOLD_EDGES = 2'h2;
  localparam logic [1:0] CLKRUN_IDLE_CLOCKS = 2'h2;

  // Reset value of the serial interrupt enable bit
  localparam logic ENABLE_RESET = 1'b1;

  // Synchroniser lanes
  localparam int unsigned SYNC_PCI_CLK = 0;
  localparam int unsigned SYNC_BUS_RST = 1;
  localparam int unsigned SYNC_SERIAL = 2;
  localparam int unsigned SYNC_CLKRUN = 3;
  localparam int unsigned SYNC_WIDTH = 4;
  localparam logic [3:0] SYNC_RESET = 4'hF;

  // Line cycle mode, decided by the stop pulse width
  typedef enum logic {
    mode_continuous = 1'b0,
    mode_quiet = 1'b1
  } sia_mode_type;

  // Serial line cycle tracker
  typedef enum logic [1:0] {
    ser_idle = 2'b00,
    ser_start = 2'b01,
    ser_frames = 2'b10
  } sia_ser_state_type;

  // Clock-run driver
  typedef enum logic {
    crun_idle = 1'b0,
    crun_drive = 1'b1
  } sia_crun_state_type;

endpackage : sia_pkg

// ---- tb/sia_agent_monitor.sv ----
/*
  Port checker for the serial interrupt agent.
  Assumes clk samples the PCI clock pin much faster than it toggles.
*/
`timescale 1ns/1ps

module sia_agent_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pins
  input wire logic pci_clk,
  input wire logic bus_reset_n,
  input wire logic serial_interrupt_in,
  input wire logic serial_interrupt_out,
  input wire logic serial_interrupt_oe,
  input wire logic clkrun_n_in,
  input wire logic clkrun_n_out,
  input wire logic clkrun_n_oe,
  // Requests and status
  input wire logic [sia_pkg::IRQ_WIDTH-1:0] irq_data,
  input wire logic system_mgmt_interrupt_n,
  input wire logic smi_on_frame3,
  input wire logic dma_req,
  input wire logic mode_write,
  input wire logic mode_write_value,
  input wire logic serial_irq_enable,
  input wire logic quiet_mode,
  input wire logic change_pending
);
  logic pin_q, pin_qq, pin_rise, low_drive;
  logic [1:0] held, high_run;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  assign pin_rise = pin_q & ~pin_qq;
  assign low_drive = serial_interrupt_oe & ~serial_interrupt_out;

  // PCI clock pin history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_q <= 1'b1;
      pin_qq <= 1'b1;
    end else begin
      pin_q <= pci_clk;
      pin_qq <= pin_q;
    end
  end

  // Rises while driving clock-run, and rises that saw the line high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      held <= 2'h0;
      high_run <= 2'h0;
    end else begin
      if (!clkrun_n_oe) held <= 2'h0;
      else if (pin_rise && held != 2'h3) held <= held + 2'h1;
      if (pin_rise) high_run <= !clkrun_n_in ? 2'h0 : high_run + {1'b0, high_run != 2'h3};
    end
  end

  a_restart_enabled: assert property ($rose(clkrun_n_oe) |-> $past(serial_irq_enable))
    else $error("clock-run driven while disabled");
  a_restart_free_line: assert property ($rose(clkrun_n_oe) |-> $past(clkrun_n_in, 3))
    else $error("clock-run driven over a held line");
  a_restart_idle_run: assert property ($rose(clkrun_n_oe) |-> high_run >= 2'h2)
    else $error("clock-run driven without two idle clocks");
  a_hold_two_rises: assert property ($fell(clkrun_n_oe) |-> held == 2'h2)
    else $error("clock-run hold not two rises");
  a_reset_quiet: assert property (!bus_reset_n [*4] |-> !serial_interrupt_oe && !quiet_mode)
    else $error("line driven or quiet during bus reset");
  a_disabled_silent: assert property (!serial_irq_enable [*3] |-> !serial_interrupt_oe)
    else $error("serial line driven while disabled");
  a_recovery_after_low: assert property ($rose(serial_interrupt_oe && serial_interrupt_out) |-> $past(low_drive))
    else $error("line driven high without a sample low");
  a_low_one_clock: assert property ($rose(low_drive) |-> low_drive [*8] ##3 !low_drive)
    else $error("low drive not one PCI clock");
  a_change_marks: assert property (serial_irq_enable && bus_reset_n && $changed(irq_data[15:3])
    |-> ##[1:2] change_pending)
    else $error("interrupt change not marked pending");

endmodule : sia_agent_monitor

bind sia_agent sia_agent_monitor mon (.clk, .resetn, .pci_clk, .bus_reset_n, .serial_interrupt_in,
  .serial_interrupt_out, .serial_interrupt_oe, .clkrun_n_in, .clkrun_n_out, .clkrun_n_oe,
  .irq_data, .system_mgmt_interrupt_n, .smi_on_frame3, .dma_req, .mode_write, .mode_write_value,
  .serial_irq_enable, .quiet_mode, .change_pending);

// ---- tb/sia_host_model.sv ----
/*
  Host serial interrupt controller and PCI clock generator.
  Assumes the bench resolves both open-drain lines with pull-ups.
*/
`timescale 1ns/1ps

module sia_host_model (
  // Clock and pulls on the shared lines
  output logic pci_clk,
  output logic serial_interrupt_pin_low,
  output logic crun_low,
  // Resolved line levels
  input wire logic serial_interrupt_pin,
  input wire logic clkrun_n
);
  logic running, timeout;
  logic [15:0] seen;

  // PCI clock, 80 ns; a stop waits for the low phase
  initial begin
    pci_clk = 1'b0;
    running = 1'b1;
    crun_low = 1'b1;
    serial_interrupt_pin_low = 1'b0;
    timeout = 1'b0;
    seen = 16'hFFFF;
    forever begin
      #40;
      if (running || pci_clk) pci_clk = ~pci_clk;
    end
  end

  always @(negedge clkrun_n) begin
    if (!running) begin
      running = 1'b1;
      repeat (2) @(posedge pci_clk);
      crun_low = 1'b1;
    end
  end

  task automatic park();
    @(negedge pci_clk);
    crun_low = 1'b0;
    repeat (4) @(posedge pci_clk);
    if (clkrun_n) begin
      @(negedge pci_clk);
      running = 1'b0;
    end
  endtask : park

  task automatic cycle(input int width, input int stop_len, input bit dev_start);
    int k;
    k = 0;
    timeout = 1'b0;
    if (dev_start) begin
      while (serial_interrupt_pin !== 1'b0 && k < 200) begin
        @(posedge pci_clk);
        k++;
      end
      timeout = (k >= 200);
      width = width - 1;
    end else begin
      @(posedge pci_clk);
    end
    serial_interrupt_pin_low = 1'b1;
    repeat (width) @(posedge pci_clk);
    serial_interrupt_pin_low = 1'b0;
    for (int m = 1; m <= 47; m++) begin
      @(posedge pci_clk);
      if (m % 3 == 2) seen[(m + 1) / 3 - 1] = serial_interrupt_pin;
    end
    // stop pulse, after the last frame's recovery and turn-around
    repeat (2) @(posedge pci_clk);
    serial_interrupt_pin_low = 1'b1;
    repeat (stop_len) @(posedge pci_clk);
    serial_interrupt_pin_low = 1'b0;
    repeat (2) @(posedge pci_clk);
  endtask : cycle

endmodule : sia_host_model

// ---- tb/tb_serial_irq_clock_run_agent.sv ----
/*
  Self-checking bench for the serial interrupt agent.
  Assumes the host model drives the PCI clock and both line pulls.
*/
`timescale 1ns/1ps

module tb_serial_irq_clock_run_agent;
  logic clk, resetn = 1'b0, bus_reset_n = 1'b1, pci_clk, serial_interrupt_pin, clkrun_n, host_low, gen_low;
  logic serial_interrupt_pin_out, serial_interrupt_pin_oe, crun_out, crun_oe, en, quiet, pend;
  logic [15:0] irq = 16'hFFFF;
  logic smi_n = 1'b1, smi_sel = 1'b0, dma = 1'b0, mw = 1'b0, mwv = 1'b0, en_exp = 1'b1;
  logic [1:0] hit;
  int n_errors = 0;
  int n_tests = 0;

  // Open-drain lines with pull-ups
  assign serial_interrupt_pin = ~((serial_interrupt_pin_oe & ~serial_interrupt_pin_out) | host_low);
  assign clkrun_n = ~((crun_oe & ~crun_out) | gen_low);

  sia_agent DUT (.clk(clk), .resetn(resetn), .pci_clk(pci_clk), .bus_reset_n(bus_reset_n),
    .serial_interrupt_in(serial_interrupt_pin), .serial_interrupt_out(serial_interrupt_pin_out), .serial_interrupt_oe(serial_interrupt_pin_oe),
    .clkrun_n_in(clkrun_n), .clkrun_n_out(crun_out), .clkrun_n_oe(crun_oe), .irq_data(irq),
    .system_mgmt_interrupt_n(smi_n), .smi_on_frame3(smi_sel), .dma_req(dma), .mode_write(mw),
    .mode_write_value(mwv), .serial_irq_enable(en), .quiet_mode(quiet), .change_pending(pend));

  sia_host_model host (.pci_clk(pci_clk), .serial_interrupt_pin_low(host_low), .crun_low(gen_low),
    .serial_interrupt_pin(serial_interrupt_pin), .clkrun_n(clkrun_n));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // Step to just after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Frame values the host should collect
  function automatic logic [15:0] expect_frames();
    logic [15:0] e;
    e = irq;
    if (smi_sel) e[2] = smi_n;
    if (!en_exp) e = 16'hFFFF;
    e[0] = 1'b1;
    return e;
  endfunction : expect_frames

  task automatic run(input int width, input int stop_len, input bit dev_start);
    host.cycle(width, stop_len, dev_start);
    check(host.seen, expect_frames());
    check({15'h0, host.timeout}, 16'h0);
  endtask : run

  // Bounded wait for a clock-run request
  task automatic wait_crun();
    int k;
    k = 0;
    n_tests++;
    while (crun_oe !== 1'b1 && k < 400) begin
      tick(1);
      k++;
    end
    if (k >= 400) begin
      n_errors++;
      complete_run();
    end
  endtask : wait_crun

  // Note any drive of either line
  task automatic watch(input int n);
    hit = 2'b00;
    repeat (n) begin
      tick(1);
      hit = hit | {crun_oe, serial_interrupt_pin_oe};
    end
  endtask : watch

  task automatic set_enable(input logic v);
    tick(1);
    mw = 1'b1;
    mwv = v;
    en_exp = v;
    tick(1);
    mw = 1'b0;
  endtask : set_enable

  initial begin
    void'($urandom(32'h7976));
    tick(20);
    resetn = 1'b1;
    tick(5);
    check({15'h0, en}, 16'h1);
    check({15'h0, quiet}, 16'h0);
    // Every start width, both frame-3 sources, random levels
    for (int i = 0; i < 5; i++) begin
      tick(1);
      irq = 16'($urandom);
      smi_n = 1'($urandom);
      smi_sel = 1'(i % 2);
      run(4 + i, (i == 4) ? 2 : 3, 1'b0);
    end
    check({15'h0, quiet}, 16'h1);
    tick(1);
    irq[5] = ~irq[5];
    run(6, 3, 1'b1);
    check({15'h0, pend}, 16'h0);
    check({15'h0, quiet}, 16'h0);
    tick(1);
    irq[7] = ~irq[7];
    watch(400);
    check({14'h0, hit}, 16'h0);
    run(8, 3, 1'b0);
    // Clock restart, then a second stop attempt while still pending
    host.park();
    tick(1);
    irq[9] = ~irq[9];
    wait_crun();
    tick(60);
    host.park();
    check({15'h0, host.running}, 16'h1);
    run(5, 3, 1'b0);
    host.park();
    watch(300);
    check({14'h0, hit}, 16'h0);
    tick(1);
    dma = 1'b1;
    wait_crun();
    tick(60);
    dma = 1'b0;
    set_enable(1'b0);
    check({15'h0, en}, 16'h0);
    irq = 16'($urandom);
    run(4, 3, 1'b0);
    host.park();
    tick(1);
    irq[3] = ~irq[3];
    dma = 1'b1;
    watch(300);
    check({14'h0, hit}, 16'h0);
    dma = 1'b0;
    set_enable(1'b1);
    tick(1);
    dma = 1'b1;
    wait_crun();
    tick(60);
    run(7, 2, 1'b0);
    check({15'h0, quiet}, 16'h1);
    bus_reset_n = 1'b0;
    tick(10);
    bus_reset_n = 1'b1;
    check({15'h0, quiet}, 16'h0);
    tick(10);
    complete_run();
  end

  // Run limit
  initial begin
    #700000;
    n_errors++;
    complete_run();
  end

endmodule : tb_serial_irq_clock_run_agent
